// ---- src/single_wire_slave_command_layer.sv ----
// Command layer of a single-wire open-drain bus slave with shadow RAM,
// EEPROM blocks and a Wishbone configuration port.
// Assumes dq_i is synchronous to clk_i; the wire is resolved outside.
// Summary of operation
// - Reset pulse answered by presence pulse
// - Read net opcode 33h or 39h
// - Match 55h: only matching slave continues
// - Skip CCh goes straight to function
// - Search F0h: bit, complement, master bit
// - Pulse fall cuts power, rise selects
// - Swap recognised only with swap_enable
// - Read 69h: data LSB after address
// - Read address increments per byte
// - Reads past FFh return ones
// - Reset pulse abandons read anywhere
// - Write 6Ch: LSB first, auto-increment
// - Writes past FFh are discarded
// - Drop protected and partial byte writes
// - EEPROM writes land in shadow RAM
// - Copy 48h stores unlocked block
// - Copy flag set, EEPROM writes dropped
// - Copy starts after address, lasts 2ms
// - Recall B8h loads block into shadow
// - Lock 6Ah needs lock enable set
// - Sample write slot within 15-60us
// - Low over 120us is a reset
`timescale 1ns/1ps
`include "swcl_defs.svh"

module single_wire_slave_command_layer
  import swcl_pkg::*;
#(
  parameter int RESET_CYC = (`T_RESET_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int SAMPLE_CYC = `T_SAMPLE_NS / `CLK_PERIOD_NS,
  parameter int PRES_WAIT_CYC = `T_PRES_WAIT_NS / `CLK_PERIOD_NS,
  parameter int PRES_LOW_CYC = `T_PRES_LOW_NS / `CLK_PERIOD_NS,
  parameter int COPY_CYC = `T_COPY_NS / `CLK_PERIOD_NS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dq_i,
  output logic dq_o,
  output logic dq_oe_o,
  output logic discharge_control_o,
  output logic charge_control_o,
  output logic swap_master_o,
  output logic sleep_o,
  output logic copy_in_progress_flag_o
);

  function automatic logic is_ee(input logic [7:0] a);
    return (a >= `MEM_EE_BASE) && (a <= `MEM_EE_LAST);
  endfunction

  function automatic logic is_sram(input logic [7:0] a);
    return (a >= `MEM_SRAM_BASE) && (a <= `MEM_SRAM_LAST);
  endfunction

  function automatic logic [31:0] wb_merge(input logic [31:0] old, input wb_req_t r);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (r.sel[i]) begin
        v[i*8 +: 8] = r.dat[i*8 +: 8];
      end
    end
    return v;
  endfunction

  state_t state_q;
  logic [6:0] bit_cnt_q;
  logic [1:0] phase_q;
  logic [7:0] shift_q;
  logic [7:0] addr_q;
  logic [7:0] func_q;
  logic past_end_q;
  logic is_swap_q;
  logic matched_q;
  logic dq_prev_q;
  logic [19:0] low_cnt_q;
  logic bus_reset_q;
  logic [19:0] slot_cnt_q;
  logic slot_act_q;
  logic [19:0] pres_cnt_q;
  logic [19:0] copy_cnt_q;
  logic copy_blk_q;
  logic eec_q;
  logic lock_en_q;
  logic [1:0] blk_lock_q;
  logic [31:0] cfg_q;
  logic [63:0] net_addr_q;
  logic [7:0] shadow_q [0:31];
  logic [7:0] eeprom_q [0:31];
  logic [7:0] sram_q [0:15];
  logic fall;
  logic rise;
  logic bit_evt;
  logic [7:0] byte_in;
  logic tx_req;
  logic tx_bit;
  logic [7:0] rd_data;
  logic cmd_fire;
  logic wr_commit;
  logic wb_go;
  logic net_bit;

  assign fall = dq_prev_q & ~dq_i;
  assign rise = ~dq_prev_q & dq_i;
  assign bit_evt = slot_act_q && (slot_cnt_q == 20'(SAMPLE_CYC - 1));
  assign byte_in = {dq_i, shift_q[7:1]};
  assign net_bit = net_addr_q[bit_cnt_q[5:0]];
  assign cmd_fire = bit_evt && (state_q == ST_FUNC_ADDR) && (bit_cnt_q == 7'd7);
  assign wb_go = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;

  // Byte seen on the read side of the memory map
  always_comb begin
    rd_data = 8'h00;
    if (addr_q == `MEM_STATUS) begin
      rd_data[`BIT_OPSEL] = cfg_q[`CFG_OPSEL];
      rd_data[`BIT_SWAP_ENABLE] = cfg_q[`CFG_SWAP_ENABLE];
    end else if (addr_q == `MEM_EEPROM_REG) begin
      rd_data = {eec_q, lock_en_q, 4'h0, blk_lock_q};
    end else if (addr_q == `MEM_SPECIAL) begin
      rd_data[`BIT_MSTR] = swap_master_o;
    end else if (is_ee(addr_q)) begin
      rd_data = shadow_q[addr_q[4:0]];
    end else if (is_sram(addr_q)) begin
      rd_data = sram_q[addr_q[3:0]];
    end
  end

  always_comb begin
    tx_req = 1'b0;
    tx_bit = 1'b1;
    case (state_q)
      ST_NET_READ: begin
        tx_req = 1'b1;
        tx_bit = net_bit;
      end
      ST_SEARCH: begin
        tx_req = (phase_q != 2'd2);
        tx_bit = (phase_q == 2'd0) ? net_bit : ~net_bit;
      end
      ST_READ: begin
        tx_req = 1'b1;
        tx_bit = past_end_q | rd_data[bit_cnt_q[2:0]];
      end
      default: begin
        tx_req = 1'b0;
        tx_bit = 1'b1;
      end
    endcase
  end

  always_comb begin
    wr_commit = 1'b0;
    if (bit_evt && state_q == ST_WRITE && bit_cnt_q == 7'd7 && !past_end_q) begin
      if (is_ee(addr_q)) begin
        wr_commit = !eec_q && !blk_lock_q[addr_q[4]];
      end else begin
        wr_commit = is_sram(addr_q) || (addr_q == `MEM_EEPROM_REG);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dq_prev_q <= 1'b1;
      low_cnt_q <= 20'h0_0000;
      bus_reset_q <= 1'b0;
    end else if (ce_i) begin
      dq_prev_q <= dq_i;
      if (dq_i || dq_oe_o) begin
        low_cnt_q <= 20'h0_0000;
      end else if (low_cnt_q != 20'(RESET_CYC)) begin
        low_cnt_q <= low_cnt_q + 20'h0_0001;
      end
      if (!dq_i && !dq_oe_o && low_cnt_q == 20'(RESET_CYC - 1)) begin
        bus_reset_q <= 1'b1;
      end else if (rise) begin
        bus_reset_q <= 1'b0;
      end
    end
  end

  // Slot timer and open-drain drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_act_q <= 1'b0;
      slot_cnt_q <= 20'h0_0000;
      pres_cnt_q <= 20'h0_0000;
      dq_oe_o <= 1'b0;
      dq_o <= 1'b0;
    end else if (ce_i) begin
      dq_o <= 1'b0;
      if (state_q == ST_PRESENCE) begin
        slot_act_q <= 1'b0;
        pres_cnt_q <= pres_cnt_q + 20'h0_0001;
        if (pres_cnt_q == 20'(PRES_WAIT_CYC - 1)) begin
          dq_oe_o <= 1'b1;
        end else if (pres_cnt_q == 20'(PRES_WAIT_CYC + PRES_LOW_CYC - 1)) begin
          dq_oe_o <= 1'b0;
        end
      end else begin
        pres_cnt_q <= 20'h0_0000;
        if (fall && !slot_act_q) begin
          slot_act_q <= 1'b1;
          slot_cnt_q <= 20'h0_0000;
          dq_oe_o <= tx_req && !tx_bit;
        end else if (slot_act_q) begin
          slot_cnt_q <= slot_cnt_q + 20'h0_0001;
          if (bit_evt) begin
            slot_act_q <= 1'b0;
            dq_oe_o <= 1'b0;
          end
        end
      end
    end
  end

  // Transaction state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_WAIT_RST;
      bit_cnt_q <= 7'd0;
      phase_q <= 2'd0;
      shift_q <= 8'h00;
      addr_q <= 8'h00;
      func_q <= 8'h00;
      past_end_q <= 1'b0;
      is_swap_q <= 1'b0;
      matched_q <= 1'b0;
    end else if (ce_i) begin
      if (bus_reset_q && rise) begin
        state_q <= ST_PRESENCE;
        bit_cnt_q <= 7'd0;
        phase_q <= 2'd0;
        past_end_q <= 1'b0;
      end else if (state_q == ST_PRESENCE) begin
        if (pres_cnt_q == 20'(PRES_WAIT_CYC + PRES_LOW_CYC - 1)) begin
          state_q <= ST_NET_CMD;
        end
      end else if (state_q == ST_SWAP_PULSE) begin
        // fall, then rise
        // The release that ends a write-0 slot must not count as the pulse
        if (fall) begin
          phase_q <= 2'd1;
        end else if (rise && phase_q == 2'd1) begin
          state_q <= ST_WAIT_RST;
        end
      end else if (bit_evt) begin
        shift_q <= byte_in;
        bit_cnt_q <= bit_cnt_q + 7'd1;
        case (state_q)
          ST_NET_CMD: begin
            if (bit_cnt_q == 7'd7) begin
              bit_cnt_q <= 7'd0;
              matched_q <= 1'b1;
              is_swap_q <= 1'b0;
              phase_q <= 2'd0;
              if (byte_in == (cfg_q[`CFG_OPSEL] ? `OP_READ_NET_B : `OP_READ_NET_A)) begin
                state_q <= ST_NET_READ;
              end else if (byte_in == `OP_MATCH_NET) begin
                state_q <= ST_NET_MATCH;
              end else if (byte_in == `OP_SKIP_NET) begin
                state_q <= ST_FUNC_CMD;
              end else if (byte_in == `OP_SEARCH_NET) begin
                state_q <= ST_SEARCH;
              end else if (byte_in == `OP_SWAP_NET && cfg_q[`CFG_SWAP_ENABLE]) begin
                state_q <= ST_NET_MATCH;
                is_swap_q <= 1'b1;
              end else begin
                state_q <= ST_WAIT_RST;
              end
            end
          end
          ST_NET_READ: begin
            if (bit_cnt_q == 7'd63) begin
              bit_cnt_q <= 7'd0;
              state_q <= ST_FUNC_CMD;
            end
          end
          ST_NET_MATCH: begin
            if (dq_i != net_bit) begin
              matched_q <= 1'b0;
            end
            if (bit_cnt_q == 7'd63) begin
              bit_cnt_q <= 7'd0;
              if (is_swap_q) begin
                state_q <= ST_SWAP_PULSE;
              end else if (matched_q && dq_i == net_bit) begin
                state_q <= ST_FUNC_CMD;
              end else begin
                state_q <= ST_WAIT_RST;
              end
            end
          end
          ST_SEARCH: begin
            bit_cnt_q <= bit_cnt_q;
            if (phase_q != 2'd2) begin
              phase_q <= phase_q + 2'd1;
            end else if (dq_i != net_bit) begin
              state_q <= ST_WAIT_RST;
            end else begin
              phase_q <= 2'd0;
              bit_cnt_q <= bit_cnt_q + 7'd1;
              if (bit_cnt_q == 7'd63) begin
                bit_cnt_q <= 7'd0;
                state_q <= ST_FUNC_CMD;
              end
            end
          end
          ST_FUNC_CMD: begin
            if (bit_cnt_q == 7'd7) begin
              bit_cnt_q <= 7'd0;
              func_q <= byte_in;
              if (byte_in == `OP_READ_DATA || byte_in == `OP_WRITE_DATA ||
                  byte_in == `OP_COPY_DATA || byte_in == `OP_RECALL_DATA ||
                  byte_in == `OP_LOCK) begin
                state_q <= ST_FUNC_ADDR;
              end else begin
                state_q <= ST_WAIT_RST;
              end
            end
          end
          ST_FUNC_ADDR: begin
            if (bit_cnt_q == 7'd7) begin
              bit_cnt_q <= 7'd0;
              addr_q <= byte_in;
              past_end_q <= 1'b0;
              if (func_q == `OP_READ_DATA) begin
                state_q <= ST_READ;
              end else if (func_q == `OP_WRITE_DATA) begin
                state_q <= ST_WRITE;
              end else begin
                state_q <= ST_WAIT_RST;
              end
            end
          end
          ST_READ, ST_WRITE: begin
            if (bit_cnt_q == 7'd7) begin
              bit_cnt_q <= 7'd0;
              addr_q <= addr_q + 8'h01;
              if (addr_q == `MEM_LAST) begin
                past_end_q <= 1'b1;
              end
            end
          end
          default: begin
            bit_cnt_q <= 7'd0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      discharge_control_o <= 1'b1;
      charge_control_o <= 1'b1;
      swap_master_o <= 1'b0;
      sleep_o <= 1'b0;
    end else if (ce_i && state_q == ST_SWAP_PULSE) begin
      if (fall) begin
        discharge_control_o <= 1'b0;
        charge_control_o <= 1'b0;
      end else if (rise && phase_q == 2'd1) begin
        discharge_control_o <= matched_q;
        charge_control_o <= matched_q;
        swap_master_o <= matched_q;
        sleep_o <= !matched_q;
      end
    end
  end

  // Shadow RAM, SRAM and lock-enable bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_en_q <= 1'b0;
      for (int i = 0; i < 32; i++) begin
        shadow_q[i] <= 8'h00;
      end
      for (int i = 0; i < 16; i++) begin
        sram_q[i] <= 8'h00;
      end
    end else if (ce_i) begin
      if (wr_commit) begin
        if (is_ee(addr_q)) begin
          shadow_q[addr_q[4:0]] <= byte_in;
        end else if (is_sram(addr_q)) begin
          sram_q[addr_q[3:0]] <= byte_in;
        end else begin
          lock_en_q <= byte_in[`BIT_LOCK_EN];
        end
      end
      if (cmd_fire && func_q == `OP_RECALL_DATA && is_ee(byte_in)) begin
        for (int i = 0; i < 16; i++) begin
          shadow_q[{byte_in[4], 4'(i)}] <= eeprom_q[{byte_in[4], 4'(i)}];
        end
      end
      if (cmd_fire && func_q == `OP_LOCK && lock_en_q) begin
        lock_en_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blk_lock_q <= 2'b00;
    end else if (ce_i && cmd_fire && func_q == `OP_LOCK && lock_en_q && is_ee(byte_in)) begin
      blk_lock_q[byte_in[4]] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eec_q <= 1'b0;
      copy_cnt_q <= 20'h0_0000;
      copy_blk_q <= 1'b0;
      copy_in_progress_flag_o <= 1'b0;
    end else if (ce_i) begin
      if (cmd_fire && func_q == `OP_COPY_DATA && is_ee(byte_in) &&
          !blk_lock_q[byte_in[4]] && !eec_q) begin
        eec_q <= 1'b1;
        copy_cnt_q <= 20'h0_0000;
        copy_blk_q <= byte_in[4];
      end else if (eec_q) begin
        copy_cnt_q <= copy_cnt_q + 20'h0_0001;
        if (copy_cnt_q == 20'(COPY_CYC - 1)) begin
          eec_q <= 1'b0;
        end
      end
      copy_in_progress_flag_o <= eec_q;
    end
  end

  // Nonvolatile array, written when the copy completes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 32; i++) begin
        eeprom_q[i] <= 8'h00;
      end
    end else if (ce_i && eec_q && copy_cnt_q == 20'(COPY_CYC - 1)) begin
      for (int i = 0; i < 16; i++) begin
        eeprom_q[{copy_blk_q, 4'(i)}] <= shadow_q[{copy_blk_q, 4'(i)}];
      end
    end
  end

  // Wishbone slave, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      cfg_q <= `CFG_RST;
      net_addr_q <= `NET_ADDR_RST;
    end else if (ce_i) begin
      wb_ack_o <= wb_go;
      wb_dat_o <= 32'h0000_0000;
      if (wb_go) begin
        if (wb_req_i.adr == `WB_CFG) begin
          wb_dat_o <= {30'h0000_0000, cfg_q[1:0]};
          if (wb_req_i.we) begin
            cfg_q <= wb_merge(cfg_q, wb_req_i) & 32'h0000_0003;
          end
        end else if (wb_req_i.adr == `WB_STATUS) begin
          wb_dat_o <= {20'h0_0000, state_q, 3'h0, blk_lock_q,
                       sleep_o, swap_master_o, eec_q};
        end else if (wb_req_i.adr == `WB_NET_LO) begin
          wb_dat_o <= net_addr_q[31:0];
          if (wb_req_i.we) begin
            net_addr_q[31:0] <= wb_merge(net_addr_q[31:0], wb_req_i);
          end
        end else if (wb_req_i.adr == `WB_NET_HI) begin
          wb_dat_o <= net_addr_q[63:32];
          if (wb_req_i.we) begin
            net_addr_q[63:32] <= wb_merge(net_addr_q[63:32], wb_req_i);
          end
        end
      end
    end
  end

endmodule // single_wire_slave_command_layer

// ---- src/swcl_defs.svh ----
// Constants for the single-wire slave command layer: opcodes, memory map,
// status bit positions and link timing. Definitions only.
`ifndef SWCL_DEFS_SVH
`define SWCL_DEFS_SVH

`define CLK_PERIOD_NS 5
// Link timing in nanoseconds
`define T_RESET_LOW_NS 120000
`define T_SAMPLE_NS 30000
`define T_PRES_WAIT_NS 30000
`define T_PRES_LOW_NS 100000
`define T_COPY_NS 2000000

// Net address opcodes
`define OP_READ_NET_A 8'h33
`define OP_READ_NET_B 8'h39
`define OP_MATCH_NET 8'h55
`define OP_SKIP_NET 8'hCC
`define OP_SEARCH_NET 8'hF0
`define OP_SWAP_NET 8'hAA
// Function opcodes
`define OP_READ_DATA 8'h69
`define OP_WRITE_DATA 8'h6C
`define OP_COPY_DATA 8'h48
`define OP_RECALL_DATA 8'hB8
`define OP_LOCK 8'h6A

// Memory map of the single-wire side
`define MEM_STATUS 8'h01
`define MEM_EEPROM_REG 8'h07
`define MEM_SPECIAL 8'h08
`define MEM_EE_BASE 8'h20
`define MEM_EE_LAST 8'h3F
`define MEM_SRAM_BASE 8'h80
`define MEM_SRAM_LAST 8'h8F
`define MEM_LAST 8'hFF
// Bit positions in the memory-mapped bytes
`define BIT_OPSEL 4
`define BIT_SWAP_ENABLE 3
`define BIT_EEC 7
`define BIT_LOCK_EN 6
`define BIT_MSTR 5

// Wishbone register offsets and fields
`define WB_CFG 8'h00
`define WB_STATUS 8'h04
`define WB_NET_LO 8'h08
`define WB_NET_HI 8'h0C
`define CFG_OPSEL 0
`define CFG_SWAP_ENABLE 1
`define CFG_RST 32'h0000_0000
// Neutral net address, value arbitrary
`define NET_ADDR_RST 64'h0123_4567_89AB_CD01

`endif

// ---- src/swcl_pkg.sv ----
// Types shared by the single-wire slave command layer.
// Assumes swcl_defs.svh for numeric constants.
package swcl_pkg;

  typedef enum logic [3:0] {
    ST_WAIT_RST,
    ST_PRESENCE,
    ST_NET_CMD,
    ST_NET_READ,
    ST_NET_MATCH,
    ST_SEARCH,
    ST_SWAP_PULSE,
    ST_FUNC_CMD,
    ST_FUNC_ADDR,
    ST_READ,
    ST_WRITE
  } state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

endpackage

// ---- tb/single_wire_slave_command_layer_tb.sv ----
// Self-checking bench for the single-wire slave command layer.
// Assumes the line master model and the bound checker.
`timescale 1ns/1ps
`include "swcl_defs.svh"
module single_wire_slave_command_layer_tb;
  import swcl_pkg::*;
  localparam int SC = 10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t wb_req_i = '0;
  logic [31:0] wb_dat_o, q;
  logic [31:0] seed = 32'h0000_4e32;
  logic wb_ack_o, dq_i, dq_o, dq_oe_o, dch, chg, mst, slp, busy, p, a, c;
  logic [63:0] na, v;
  logic [7:0] d0, d1, d2;
  int n_errors = 0;
  int comparisons = 0;

  always #2.5 clk_i = ~clk_i;

  single_wire_slave_command_layer #(
    .RESET_CYC(40), .SAMPLE_CYC(SC), .PRES_WAIT_CYC(5), .PRES_LOW_CYC(12), .COPY_CYC(1500)
  ) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .discharge_control_o(dch), .charge_control_o(chg), .swap_master_o(mst),
    .sleep_o(slp), .copy_in_progress_flag_o(busy)
  );
  swcl_line_master #(.SC(SC)) m (.clk_i(clk_i), .dev_oe_i(dq_oe_o), .line_o(dq_i));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h8020_0003 : s >> 1;
  endfunction

  function automatic logic [1:0] srch(input logic [63:0] ad, input int i);
    return {ad[i], ~ad[i]};
  endfunction

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: ad, sel: 4'hf, dat: d};
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_req_i <= '0;
  endtask

  task automatic skp(input logic [7:0] f, input logic [7:0] ad);
    m.rst(p);
    chk("presence", p, 1);
    m.wbits(8, 8'hCC);
    m.wbits(16, {ad, f});
  endtask

  task automatic end_of_test;
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    end_of_test;
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    seed = lfsr(seed);
    na[63:32] = seed;
    seed = lfsr(seed);
    na[31:0] = seed;
    seed = lfsr(seed);
    {d2, d1, d0} = seed[23:0];
    chk("ctl", {chg, dch, mst, slp}, 4'hc);
    wb(1'b1, `WB_NET_LO, na[31:0]);
    wb(1'b1, `WB_NET_HI, na[63:32]);
    wb(1'b0, `WB_NET_HI, 32'h0000_0000);
    chk("wb_net", q, na[63:32]);
    wb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", q, 0);
    for (int o = 0; o < 2; o++) begin
      wb(1'b1, `WB_CFG, 32'(o));
      m.rst(p);
      m.wbits(8, o ? 8'h39 : 8'h33); // one slave only
      m.rbits(64, v);
      chk("net", v, na);
      m.rst(p);
      m.wbits(8, o ? 8'h33 : 8'h39);
      m.rbits(8, v);
      chk("ignored", v[7:0], 8'hff);
    end
    skp(8'h6C, 8'h80);
    m.wbits(24, {d2, d1, d0});
    skp(8'h6C, 8'h82);
    m.wbits(4, ~d2);
    skp(8'h6C, 8'h01);
    m.wbits(8, 8'hE7);
    skp(8'h69, 8'h01);
    m.rbits(8, v);
    chk("ro", v[7:0], 8'h10);
    skp(8'h69, 8'h80);
    m.rbits(24, v);
    chk("rd", v[23:0], {d2, d1, d0});
    for (int k = 0; k < 2; k++) begin
      m.rst(p);
      m.wbits(8, 8'h55);
      m.wbits(64, na ^ 64'(k));
      m.wbits(16, 16'h8069);
      m.rbits(12, v);
      chk("match", v[11:0], k ? 12'hfff : {d1[3:0], d0});
    end
    skp(8'h69, 8'hFF);
    m.rbits(16, v);
    chk("past_end", v[15:0], 16'hff00);
    skp(8'h6C, 8'h20);
    m.wbits(8, d0);
    skp(8'h48, 8'h20);
    chk("busy", busy, 1);
    skp(8'h6C, 8'h20);
    m.wbits(8, ~d0);
    for (int i = 0; i < 1600 && busy === 1'b1; i++) @(posedge clk_i);
    chk("idle", busy, 0);
    skp(8'h6C, 8'h20);
    m.wbits(8, d1);
    skp(8'h69, 8'h20);
    m.rbits(8, v);
    chk("shadow", v[7:0], d1);
    skp(8'hB8, 8'h20);
    skp(8'h69, 8'h20);
    m.rbits(8, v);
    chk("recall", v[7:0], d0);
    skp(8'h6C, 8'h07);
    m.wbits(8, 8'h40);
    skp(8'h6A, 8'h30);
    skp(8'h6C, 8'h30);
    m.wbits(8, d2 | 8'h01);
    skp(8'h48, 8'h30);
    chk("no_copy", busy, 0);
    skp(8'h69, 8'h07);
    m.rbits(8, v);
    chk("lock", v[7:0], 8'h02);
    skp(8'h69, 8'h30);
    m.rbits(8, v);
    chk("locked", v[7:0], 8'h00);
    m.rst(p);
    m.wbits(8, 8'hF0);
    for (int i = 0; i < 64; i++) begin
      m.rbit(a);
      m.rbit(c);
      chk("search", {a, c}, srch(na, i));
      m.wbit(na[i]);
    end
    m.rst(p);
    m.wbits(8, 8'hF0);
    m.rbits(2, v);
    m.wbit(~na[0]);
    m.rbits(2, v);
    chk("loser", v[1:0], 2'b11);
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, `WB_CFG, {30'h0, k < 2, 1'b0});
      m.rst(p);
      m.wbits(8, 8'hAA);
      m.wbits(64, k == 1 ? na : na ^ 64'h1);
      @(posedge clk_i) m.low_q <= 1'b1;
      repeat (8) @(posedge clk_i);
      v[1:0] = {chg, dch};
      m.low_q <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("swap", {v[1:0], chg, dch, mst, slp}, k == 0 ? 6'h01 : k == 1 ? 6'h0e : 6'h3e);
    end
    end_of_test;
  end
endmodule // single_wire_slave_command_layer_tb

// ---- tb/swcl_checker_assertions.sv ----
// Port checker for the single-wire slave command layer.
// Assumes it is bound to the top module and gets its count parameters.
`timescale 1ns/1ps
module swcl_checker
  import swcl_pkg::*;
#(
  parameter int COPY_CYC = 400000,
  parameter int PRES_LOW_CYC = 20000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire wb_req_t wb_req_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic dq_i,
  input wire logic dq_o,
  input wire logic dq_oe_o,
  input wire logic discharge_control_o,
  input wire logic charge_control_o,
  input wire logic swap_master_o,
  input wire logic sleep_o,
  input wire logic copy_in_progress_flag_o
);
  int cp_q;
  int oe_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Run lengths of copy busy and of line drive
  always_ff @(posedge clk_i) begin
    cp_q <= (rst_i || !copy_in_progress_flag_o) ? 0 : cp_q + 1;
  end
  always_ff @(posedge clk_i) begin
    oe_q <= (rst_i || !dq_oe_o) ? 0 : oe_q + 1;
  end

  property p_ack_next;
    wb_req_i.cyc && wb_req_i.stb && !wb_ack_o && ce_i |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
  property p_open_drain;
    dq_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  property p_make_high;
    $rose(charge_control_o) || $rose(discharge_control_o) |-> dq_i;
  endproperty
  a_make_high: assert property (p_make_high) else $error("power on with line low");
  property p_break_low;
    $fell(charge_control_o) || $fell(discharge_control_o) |-> !dq_i;
  endproperty
  a_break_low: assert property (p_break_low) else $error("power cut with line high");
  property p_sleep_alone;
    sleep_o |-> !swap_master_o;
  endproperty
  a_sleep_alone: assert property (p_sleep_alone) else $error("asleep yet selected");
  property p_copy_len;
    $fell(copy_in_progress_flag_o) |-> cp_q == COPY_CYC;
  endproperty
  a_copy_len: assert property (p_copy_len) else $error("copy length wrong");
  property p_oe_bound;
    oe_q <= PRES_LOW_CYC;
  endproperty
  a_oe_bound: assert property (p_oe_bound) else $error("line held low too long");

  c_write: cover property (wb_ack_o && wb_req_i.we);
  c_copy: cover property ($fell(copy_in_progress_flag_o));
  c_master: cover property ($rose(swap_master_o));
  c_sleep: cover property ($rose(sleep_o));
endmodule // swcl_checker

bind single_wire_slave_command_layer swcl_checker #(
  .COPY_CYC(COPY_CYC),
  .PRES_LOW_CYC(PRES_LOW_CYC)
) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(wb_req_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dq_i(dq_i), .dq_o(dq_o),
  .dq_oe_o(dq_oe_o), .discharge_control_o(discharge_control_o),
  .charge_control_o(charge_control_o), .swap_master_o(swap_master_o),
  .sleep_o(sleep_o), .copy_in_progress_flag_o(copy_in_progress_flag_o)
);

// ---- tb/swcl_line_master.sv ----
// Single-wire bus master model with the line pull-up.
// Assumes write slots of 2*SC+1 cycles; the bench calls its tasks.
`timescale 1ns/1ps
module swcl_line_master #(
  parameter int SC = 10,
  parameter int RST = 60
) (
  input wire logic clk_i,
  input wire logic dev_oe_i,
  output logic line_o
);
  logic low_q = 1'b0;

  // Wired-AND with pull-up
  assign line_o = ~(low_q | dev_oe_i);

  task automatic rst(output logic p);
    p = 1'b0;
    @(posedge clk_i) low_q <= 1'b1;
    repeat (RST) @(posedge clk_i);
    low_q <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_i);
      if (i > 1 && line_o === 1'b0) p = 1'b1;
    end
  endtask

  // level held across the sample point
  task automatic wbit(input logic b);
    @(posedge clk_i) low_q <= 1'b1;
    repeat (b ? 2 : SC + 4) @(posedge clk_i);
    low_q <= 1'b0;
    repeat (b ? 2 * SC - 2 : SC - 4) @(posedge clk_i);
  endtask

  task automatic rbit(output logic b);
    @(posedge clk_i) low_q <= 1'b1;
    @(posedge clk_i) low_q <= 1'b0;
    repeat (SC / 2) @(posedge clk_i);
    b = line_o;
    repeat (SC + 3) @(posedge clk_i);
  endtask

  task automatic wbits(input int n, input logic [63:0] v);
    for (int i = 0; i < n; i++) wbit(v[i]);
  endtask

  task automatic rbits(input int n, output logic [63:0] v);
    logic b;
    v = '0;
    for (int i = 0; i < n; i++) begin
      rbit(b);
      v[i] = b;
    end
  endtask
endmodule // swcl_line_master
